// ### hw/prs_pkg.sv
package prs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] CLK_HZ = 32'd50_000_000;
  localparam logic [31:0] CYC_PER_MS = CLK_HZ / 32'd1000;

  // reset pulse width, typical figure
  localparam logic [31:0] RESET_PULSE_WIDTH_MS = 32'd140;
  localparam logic [31:0] RESET_PULSE_WIDTH_CYC = RESET_PULSE_WIDTH_MS * CYC_PER_MS;

  // button hold delay, plain default
  localparam logic [31:0] BUTTON_HOLD_DELAY_MS = 32'd2000;
  localparam logic [31:0] BUTTON_HOLD_DELAY_CYC = BUTTON_HOLD_DELAY_MS * CYC_PER_MS;

  // watchdog timeout, plain default
  localparam logic [31:0] WDOG_TIMEOUT_MS = 32'd1600;
  localparam logic [31:0] WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * CYC_PER_MS;

  // manual reset debounce time, plain default
  localparam logic [31:0] DEBOUNCE_MS = 32'd20;
  localparam logic [31:0] DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int NUM_BUTTONS = 2;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;

  // external levels, all asynchronous to CLK
  typedef struct packed {
    logic [NUM_BUTTONS-1:0] btn_n;
    logic manual_reset_input_n;
    logic supply_low;
    logic supply_ok;
    logic wdog_strobe;
    logic ce_n;
    logic seal_request;
  } prs_in_t;

  localparam prs_in_t IN_IDLE = '{
    btn_n: {NUM_BUTTONS{1'b1}},
    manual_reset_input_n: 1'b1,
    supply_low: 1'b0,
    supply_ok: 1'b0,
    wdog_strobe: 1'b0,
    ce_n: 1'b1,
    seal_request: 1'b0
  };

  // whole block state
  typedef struct packed {
    prs_in_t s1;
    prs_in_t s2;
    logic wdog_prev;
    logic ok_prev;
    logic seal_prev;
    logic [31:0] hold_cnt;
    logic [31:0] deb_cnt;
    logic [31:0] wdog_cnt;
    logic [31:0] width_cnt;
    logic hold_done;
    logic armed;
    logic btn_fire;
    logic mr_db;
    logic stretch;
    logic reset_out;
    logic ce_n_out;
    logic switch_en;
    logic seal;
    logic batt_conn;
  } prs_state_t;

  localparam prs_state_t STATE_INIT = '{
    s1: IN_IDLE,
    s2: IN_IDLE,
    armed: 1'b1,
    stretch: 1'b1,
    reset_out: 1'b1,
    ce_n_out: 1'b1,
    default: '0
  };

endpackage

// ### hw/prs_supervisor.sv
`timescale 1ns/10ps
// How it works
// - reset from buttons only after all enabled buttons held together for hold delay
// - pulse variant gives exactly one reset pulse per qualified hold
// - pulse variant re-arms only once every enabled button is released
// - level variant holds reset while buttons stay pressed past the hold delay
// - outside reset the chip-select passes through unchanged
// - during reset the gated chip-select is held inactive
// - watchdog not restarted before timeout asserts reset
// - backup switchover stays off until supply-ok has been seen once
// - freshness seal keeps the battery disconnected
// - seal holds until supply-ok next rises, then clears
// - supply-low asserts reset, held for the pulse width after it ends
// - after power-up a reset pulse of the pulse width is produced
// - manual reset input is debounced internally
module prs_supervisor
  import prs_pkg::*;
#(
  parameter logic [31:0] HOLD_CYC = BUTTON_HOLD_DELAY_CYC,
  parameter logic [31:0] WIDTH_CYC = RESET_PULSE_WIDTH_CYC,
  parameter logic [31:0] WDOG_CYC = WDOG_TIMEOUT_CYC,
  parameter logic [31:0] DEB_CYC = DEBOUNCE_CYC
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // configuration from on-chip logic
  input wire logic [NUM_BUTTONS-1:0] BUTTON_ENABLE,
  input wire logic BUTTON_PULSE_MODE,
  // pins
  input wire logic [NUM_BUTTONS-1:0] BUTTON_N,
  input wire logic MANUAL_RESET_INPUT_N,
  input wire logic SUPPLY_LOW,
  input wire logic SUPPLY_OK,
  input wire logic WDOG_STROBE,
  input wire logic SEAL_REQUEST,
  // chip-select path
  input wire logic CE_N_IN,
  output logic CE_N_OUT,
  // reset and backup control
  output logic RESET_OUT,
  output logic SWITCHOVER_EN,
  output logic BATTERY_CONNECT,
  output logic SEAL_ACTIVE
);

  prs_state_t state;
  prs_state_t next_state;
  prs_in_t pins;
  logic [NUM_BUTTONS-1:0] pressed;
  logic all_pressed;
  logic any_pressed;
  logic level_req;
  logic manual_now;
  logic wdog_edge;
  logic wdog_fire;
  logic req;
  logic ok_rise;
  logic seal_set;

  always_comb
  begin
    pins.btn_n = BUTTON_N;
    pins.manual_reset_input_n = MANUAL_RESET_INPUT_N;
    pins.supply_low = SUPPLY_LOW;
    pins.supply_ok = SUPPLY_OK;
    pins.wdog_strobe = WDOG_STROBE;
    pins.ce_n = CE_N_IN;
    pins.seal_request = SEAL_REQUEST;
  end

  always_comb
  begin
    next_state = state;
    // ----------------------------------------------------------------
    // two-stage synchroniser; stage one feeds only stage two
    // ----------------------------------------------------------------
    next_state.s1 = pins;
    next_state.s2 = state.s1;

    // ----------------------------------------------------------------
    // button qualification
    // ----------------------------------------------------------------
    pressed = ~state.s2.btn_n & BUTTON_ENABLE;
    // an empty mask never qualifies, so a stray config cannot reset
    all_pressed = (pressed == BUTTON_ENABLE) && (|BUTTON_ENABLE);
    any_pressed = |pressed;
    if (!all_pressed)
    begin
      next_state.hold_cnt = CNT_ZERO;
      next_state.hold_done = 1'b0;
    end
    else if (!state.hold_done)
    begin
      if (state.hold_cnt >= HOLD_CYC - CNT_ONE)
      begin
        next_state.hold_done = 1'b1;
      end
      else
      begin
        next_state.hold_cnt = state.hold_cnt + CNT_ONE;
      end
    end

    next_state.btn_fire = 1'b0;
    if (!any_pressed)
    begin
      next_state.armed = 1'b1;
    end
    else if (BUTTON_PULSE_MODE && state.hold_done && state.armed)
    begin
      next_state.btn_fire = 1'b1;
      next_state.armed = 1'b0;
    end
    // level variant bypasses the stretch so release ends reset at once
    level_req = !BUTTON_PULSE_MODE && state.hold_done;

    // ----------------------------------------------------------------
    // manual reset debounce
    // ----------------------------------------------------------------
    manual_now = ~state.s2.manual_reset_input_n;
    if (manual_now == state.mr_db)
    begin
      next_state.deb_cnt = CNT_ZERO;
    end
    else if (state.deb_cnt >= DEB_CYC - CNT_ONE)
    begin
      next_state.mr_db = manual_now;
      next_state.deb_cnt = CNT_ZERO;
    end
    else
    begin
      next_state.deb_cnt = state.deb_cnt + CNT_ONE;
    end

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    wdog_edge = state.s2.wdog_strobe & ~state.wdog_prev;
    next_state.wdog_prev = state.s2.wdog_strobe;
    wdog_fire = 1'b0;
    // held idle during reset: software cannot strobe while held
    if (state.reset_out || wdog_edge)
    begin
      next_state.wdog_cnt = CNT_ZERO;
    end
    else if (state.wdog_cnt >= WDOG_CYC - CNT_ONE)
    begin
      wdog_fire = 1'b1;
      next_state.wdog_cnt = CNT_ZERO;
    end
    else
    begin
      next_state.wdog_cnt = state.wdog_cnt + CNT_ONE;
    end

    // ----------------------------------------------------------------
    // combined request and pulse stretch
    // ----------------------------------------------------------------
    req = state.s2.supply_low | state.mr_db | state.btn_fire | wdog_fire;
    if (req)
    begin
      next_state.stretch = 1'b1;
      next_state.width_cnt = CNT_ZERO;
    end
    else if (state.stretch)
    begin
      if (state.width_cnt >= WIDTH_CYC - CNT_ONE)
      begin
        next_state.stretch = 1'b0;
        next_state.width_cnt = CNT_ZERO;
      end
      else
      begin
        next_state.width_cnt = state.width_cnt + CNT_ONE;
      end
    end
    next_state.reset_out = next_state.stretch | level_req;
    // gate on the next reset value so blocking starts with reset itself
    next_state.ce_n_out = next_state.reset_out | state.s2.ce_n;

    // ----------------------------------------------------------------
    // backup switchover and freshness seal
    // ----------------------------------------------------------------
    ok_rise = state.s2.supply_ok & ~state.ok_prev;
    next_state.ok_prev = state.s2.supply_ok;
    if (state.s2.supply_ok)
    begin
      next_state.switch_en = 1'b1;
    end
    seal_set = state.s2.seal_request & ~state.seal_prev;
    next_state.seal_prev = state.s2.seal_request;
    if (seal_set)
    begin
      next_state.seal = 1'b1;
    end
    else if (ok_rise)
    begin
      next_state.seal = 1'b0;
    end
    next_state.batt_conn = next_state.switch_en & ~next_state.seal;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state <= STATE_INIT;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign RESET_OUT = state.reset_out;
  assign CE_N_OUT = state.ce_n_out;
  assign SWITCHOVER_EN = state.switch_en;
  assign BATTERY_CONNECT = state.batt_conn;
  assign SEAL_ACTIVE = state.seal;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  ce_block_a: assert property (state.reset_out |-> state.ce_n_out)
    else $error("chip-select not blocked during reset");

  ce_pass_a: assert property (!state.reset_out |-> state.ce_n_out == $past(state.s2.ce_n))
    else $error("chip-select not passed through");

  sup_low_a: assert property (state.s2.supply_low |=> state.reset_out[*2])
    else $error("supply low did not hold reset");

  stretch_hold_a: assert property ($fell(state.s2.supply_low) |-> state.reset_out[*8])
    else $error("reset released too soon after supply low");

  por_a: assert property ($fell(RST) |-> state.reset_out[*8])
    else $error("no power-up reset pulse");

  wdog_fire_a: assert property (
    !state.reset_out && state.wdog_cnt >= WDOG_CYC - CNT_ONE && !wdog_edge
    |=> state.reset_out && state.wdog_cnt == CNT_ZERO)
    else $error("watchdog timeout gave no reset");

  hold_drop_a: assert property (!all_pressed |=> state.hold_cnt == CNT_ZERO && !state.hold_done)
    else $error("hold count survived a release");

  hold_full_a: assert property ($rose(state.hold_done)
    |-> $past(state.hold_cnt) >= HOLD_CYC - CNT_ONE && $past(all_pressed))
    else $error("hold qualified before full delay");

  one_pulse_a: assert property (state.btn_fire
    |=> !state.btn_fire && (!state.armed || !$past(any_pressed)))
    else $error("more than one button pulse per hold");

  rearm_a: assert property (!state.armed && any_pressed |=> !state.btn_fire)
    else $error("button pulse without release");

  level_hold_a: assert property (!BUTTON_PULSE_MODE && state.hold_done && all_pressed
    |=> state.reset_out)
    else $error("level variant dropped reset while held");

  deb_a: assert property ($changed(state.mr_db) |-> $past(state.deb_cnt) >= DEB_CYC - CNT_ONE)
    else $error("manual reset changed without debounce");

  switch_a: assert property (!state.switch_en && !state.s2.supply_ok |=> !state.switch_en)
    else $error("switchover enabled before supply seen");

  seal_off_a: assert property (state.seal |-> !state.batt_conn)
    else $error("battery connected while sealed");

  seal_clear_a: assert property (ok_rise && !seal_set |=> !state.seal)
    else $error("seal not cleared on supply rise");

  // short holds must not qualify before the counter reaches its end
  hold_early_a: assert property (all_pressed && !state.hold_done
    && state.hold_cnt < HOLD_CYC - CNT_ONE |=> !state.hold_done)
    else $error("hold qualified early");

  fire_reset_a: assert property (state.btn_fire |=> state.reset_out)
    else $error("button pulse gave no reset");

  level_drop_a: assert property (!BUTTON_PULSE_MODE && !state.hold_done && !req
    && !state.stretch |=> !state.reset_out)
    else $error("level variant kept reset after release");

  width_end_a: assert property (state.stretch && !req
    && state.width_cnt >= WIDTH_CYC - CNT_ONE |=> !state.stretch)
    else $error("reset pulse overran its width");

  manual_req_a: assert property (state.mr_db |=> state.reset_out)
    else $error("manual reset gave no reset");

  wdog_idle_a: assert property (state.reset_out |=> state.wdog_cnt == CNT_ZERO)
    else $error("watchdog ran during reset");

  seal_keep_a: assert property (state.seal && !ok_rise |=> state.seal)
    else $error("seal dropped without supply rise");

endmodule

// ### verification/prs_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// host processor and sram seen from the supervisor
// ----------------------------------------------------------------
module prs_host_model
(
  // clock
  input wire logic CLK,
  // bench control
  input wire logic strobe_en,
  input wire logic ce_req,
  // supervisor side
  input wire logic RESET_OUT,
  input wire logic CE_N_OUT,
  output logic WDOG_STROBE,
  output logic CE_N_IN,
  output logic [15:0] sram_hits
);
  logic [4:0] cnt = 5'h00;

  // software strobes every 20 cycles, well inside the timeout
  always @(posedge CLK)
  begin
    cnt <= #1 (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
    WDOG_STROBE <= #1 strobe_en & (cnt < 5'h02);
  end

  // host selects the sram only on request; sram counts selected cycles
  assign CE_N_IN = ~ce_req;
  initial sram_hits = 16'h0000;
  always @(posedge CLK)
  begin
    if (CE_N_OUT === 1'b0)
    begin
      sram_hits <= sram_hits + 16'h0001;
    end
  end
endmodule

// ### verification/tb.sv
`timescale 1ns/10ps
module tb;
  import prs_pkg::*;
  localparam logic [31:0] H = 32'd20;
  localparam logic [31:0] W = 32'd16;
  localparam logic [31:0] WD = 32'd60;
  localparam logic [31:0] DB = 32'd5;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [1:0] BUTTON_ENABLE = 2'h3;
  logic BUTTON_PULSE_MODE = 1'b1;
  logic [1:0] BUTTON_N = 2'h3;
  logic MANUAL_RESET_INPUT_N = 1'b1;
  logic SUPPLY_LOW = 1'b0;
  logic SUPPLY_OK = 1'b0;
  logic SEAL_REQUEST = 1'b0;
  logic strobe_en = 1'b1;
  logic ce_req = 1'b0;
  logic WDOG_STROBE, CE_N_IN, CE_N_OUT, RESET_OUT, SWITCHOVER_EN, BATTERY_CONNECT, SEAL_ACTIVE;
  logic [15:0] sram_hits;
  logic [15:0] hits0;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;

  // ----------------------------------------------------------------
  // clock, design and partner
  // ----------------------------------------------------------------
  always #10 CLK = ~CLK;

  prs_supervisor #(.HOLD_CYC(H), .WIDTH_CYC(W), .WDOG_CYC(WD), .DEB_CYC(DB)) u_dut (
    .CLK(CLK), .RST(RST), .BUTTON_ENABLE(BUTTON_ENABLE), .BUTTON_PULSE_MODE(BUTTON_PULSE_MODE),
    .BUTTON_N(BUTTON_N), .MANUAL_RESET_INPUT_N(MANUAL_RESET_INPUT_N), .SUPPLY_LOW(SUPPLY_LOW),
    .SUPPLY_OK(SUPPLY_OK), .WDOG_STROBE(WDOG_STROBE), .SEAL_REQUEST(SEAL_REQUEST),
    .CE_N_IN(CE_N_IN), .CE_N_OUT(CE_N_OUT), .RESET_OUT(RESET_OUT),
    .SWITCHOVER_EN(SWITCHOVER_EN), .BATTERY_CONNECT(BATTERY_CONNECT), .SEAL_ACTIVE(SEAL_ACTIVE));

  prs_host_model u_host (.CLK(CLK), .strobe_en(strobe_en), .ce_req(ce_req),
    .RESET_OUT(RESET_OUT), .CE_N_OUT(CE_N_OUT), .WDOG_STROBE(WDOG_STROBE),
    .CE_N_IN(CE_N_IN), .sram_hits(sram_hits));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // bounded wait on the reset output; n returns cycles waited
  task automatic wait_rst(input logic exp, input int lim, output int k);
    k = 0;
    while (RESET_OUT !== exp && k < lim)
    begin
      cyc(1);
      k++;
    end
    check("reset_wait", RESET_OUT, exp);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // limit is far above the sum of all scenario waits
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles >= 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    cyc(5);
    check("por_high", RESET_OUT, 1'b1);
    check("switch_off", SWITCHOVER_EN, 1'b0);
    cyc(25);
    check("por_low", RESET_OUT, 1'b0);
    ce_req = 1'b1;
    cyc(4);
    check("ce_pass_low", CE_N_OUT, 1'b0);
    ce_req = 1'b0;
    cyc(4);
    check("ce_pass_high", CE_N_OUT, 1'b1);
    $display("test powerup done");
  endtask

  task automatic t_pulse();
    BUTTON_N = 2'h0;
    cyc(15);
    BUTTON_N = 2'h2;
    cyc(10);
    BUTTON_N = 2'h0;
    cyc(15);
    BUTTON_N = 2'h3;
    cyc(10);
    check("short_press", RESET_OUT, 1'b0);
    BUTTON_N = 2'h0;
    wait_rst(1'b1, 30, n);
    check("hold_long_enough", 16'(n >= 20), 16'h1);
    ce_req = 1'b1;
    hits0 = sram_hits;
    cyc(8);
    check("ce_blocked", CE_N_OUT, 1'b1);
    check("sram_untouched", sram_hits, hits0);
    cyc(60);
    check("one_pulse", RESET_OUT, 1'b0);
    check("ce_back", CE_N_OUT, 1'b0);
    ce_req = 1'b0;
    BUTTON_N = 2'h3;
    cyc(5);
    BUTTON_N = 2'h0;
    wait_rst(1'b1, 30, n);
    BUTTON_N = 2'h3;
    wait_rst(1'b0, 30, n);
    // one enabled button alone qualifies; an empty mask never does
    BUTTON_ENABLE = 2'h1;
    BUTTON_N = 2'h2;
    wait_rst(1'b1, 30, n);
    BUTTON_N = 2'h3;
    wait_rst(1'b0, 30, n);
    BUTTON_ENABLE = 2'h0;
    BUTTON_N = 2'h0;
    cyc(30);
    check("empty_mask", RESET_OUT, 1'b0);
    BUTTON_N = 2'h3;
    cyc(5);
    BUTTON_ENABLE = 2'h3;
    cyc(2);
    $display("test pulse done");
  endtask

  task automatic t_level();
    BUTTON_PULSE_MODE = 1'b0;
    BUTTON_N = 2'h0;
    wait_rst(1'b1, 30, n);
    cyc(40);
    check("level_held", RESET_OUT, 1'b1);
    BUTTON_N = 2'h3;
    cyc(5);
    check("level_release", RESET_OUT, 1'b0);
    BUTTON_PULSE_MODE = 1'b1;
    $display("test level done");
  endtask

  task automatic t_supply_manual();
    SUPPLY_LOW = 1'b1;
    cyc(4);
    check("low_assert", RESET_OUT, 1'b1);
    cyc(10);
    SUPPLY_LOW = 1'b0;
    cyc(12);
    check("low_stretch", RESET_OUT, 1'b1);
    cyc(10);
    check("low_release", RESET_OUT, 1'b0);
    // manual reset input: a 3-cycle low is ignored, a held low gives reset
    MANUAL_RESET_INPUT_N = 1'b0;
    cyc(3);
    MANUAL_RESET_INPUT_N = 1'b1;
    cyc(10);
    check("bounce_ignored", RESET_OUT, 1'b0);
    MANUAL_RESET_INPUT_N = 1'b0;
    wait_rst(1'b1, 15, n);
    MANUAL_RESET_INPUT_N = 1'b1;
    wait_rst(1'b0, 40, n);
    $display("test supply manual done");
  endtask

  task automatic t_watchdog();
    strobe_en = 1'b0;
    cyc(30);
    check("wdog_quiet", RESET_OUT, 1'b0);
    wait_rst(1'b1, 45, n);
    strobe_en = 1'b1;
    wait_rst(1'b0, 40, n);
    cyc(150);
    check("wdog_fed", RESET_OUT, 1'b0);
    $display("test watchdog done");
  endtask

  task automatic t_seal();
    SUPPLY_OK = 1'b1;
    cyc(5);
    check("switch_on", SWITCHOVER_EN, 1'b1);
    check("batt_on", BATTERY_CONNECT, 1'b1);
    SUPPLY_OK = 1'b0;
    SEAL_REQUEST = 1'b1;
    cyc(5);
    SEAL_REQUEST = 1'b0;
    cyc(20);
    check("seal_set", SEAL_ACTIVE, 1'b1);
    check("batt_cut", BATTERY_CONNECT, 1'b0);
    SUPPLY_OK = 1'b1;
    cyc(5);
    check("seal_clear", SEAL_ACTIVE, 1'b0);
    check("batt_back", BATTERY_CONNECT, 1'b1);
    $display("test seal done");
  endtask

  initial
  begin
    cyc(16);
    RST = 1'b0;
    t_powerup();
    t_pulse();
    t_level();
    t_supply_manual();
    t_watchdog();
    t_seal();
    print_verdict();
  end
endmodule
